// ### eeprom_write_guard_bench.sv
// testbench: register-level tests of the eeprom write guard
`timescale 1ns/1ps
`include "ewg_defines.vh"
module eeprom_write_guard_bench;
  logic hclk, hresetn, por_n, hsel, hwrite, data_protect_fuse, ext_req, ext_wr;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ext_addr, ext_wdata;
  wire [31:0] hrdata;
  wire [7:0] ext_rdata_ff;
  wire hreadyout, hresp, ext_deny_ff, irq;
  int n_errors, n_tests;
  ewg_guard #(.PWRT_CYCLES(20)) i_dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .data_protect_fuse(data_protect_fuse),
    .ext_req(ext_req), .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata_ff(ext_rdata_ff), .ext_deny_ff(ext_deny_ff), .irq(irq));
  always #2.5 hclk = ~hclk;
  task close_out;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // single ahb-lite transfer; the slave may stretch either phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task unl;
    xfer(1'b1, 8'h04, {24'h0, `EWG_UNLOCK_B1});
    xfer(1'b1, 8'h04, {24'h0, `EWG_UNLOCK_B2});
  endtask
  task ci(input logic e);
    @(posedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    #50000;
    n_errors++;
    close_out;
  end
  initial begin
    hclk = 0; hresetn = 0; por_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
    hwdata = 0; data_protect_fuse = 1; ext_req = 0; ext_wr = 0; ext_addr = 0; ext_wdata = 0;
    n_errors = 0; n_tests = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    por_n <= 1'b1;
    rc(8'h00, 32'hffffffff, 32'h0);
    unl;
    xfer(1'b1, 8'h00, 32'h06);
    rc(8'h00, 32'h02, 32'h0);
    repeat (40) @(posedge hclk);
    xfer(1'b1, 8'h00, 32'h06);
    rc(8'h00, 32'h02, 32'h0);
    unl;
    xfer(1'b1, 8'h00, 32'h86);
    rc(8'h00, 32'h02, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h08, 32'h05);
    xfer(1'b1, 8'h10, 32'h3c);
    xfer(1'b1, 8'h1c, 32'h10);
    unl;
    xfer(1'b1, 8'h00, 32'h06);
    rc(8'h00, 32'h02, 32'h02);
    repeat (`EWG_WRITE_CYCLES + 4) @(posedge hclk);
    rc(8'h20, 32'h10, 32'h10);
    ci(1'b1);
    xfer(1'b1, 8'h1c, 32'h0);
    ci(1'b0);
    xfer(1'b1, 8'h1c, 32'h10);
    ci(1'b1);
    xfer(1'b1, 8'h24, 32'h10);
    ci(1'b0);
    xfer(1'b1, 8'h10, 32'h0);
    xfer(1'b1, 8'h00, 32'h01);
    repeat (4) @(posedge hclk);
    rc(8'h10, 32'hff, 32'h3c);
    rc(8'h3c, 32'hffffffff, 32'h0);
    xfer(1'b1, 8'h0c, 32'hff);
    rc(8'h0c, 32'hffffffff, 32'h0f);
    xfer(1'b1, 8'h14, 32'hff);
    rc(8'h14, 32'hffffffff, 32'h3f);
    xfer(1'b1, 8'h18, 32'ha5);
    rc(8'h18, 32'hffffffff, 32'ha5);
    rc(8'h28, 32'hffffffff, 32'h1);
    ext_addr <= 8'h05;
    ext_req <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({24'h0, ext_rdata_ff}, 32'h3c);
    chk({31'h0, ext_deny_ff}, 32'h0);
    // open fuse: one external write lands; then the fuse closes and a second one must not
    ext_addr <= 8'h06;
    ext_wdata <= 8'h5a;
    ext_wr <= 1'b1;
    @(posedge hclk);
    ext_addr <= 8'h05;
    ext_wdata <= 8'hff;
    data_protect_fuse <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({31'h0, ext_deny_ff}, 32'h1);
    ext_req <= 1'b0;
    ext_wr <= 1'b0;
    rc(8'h20, 32'h01, 32'h01);
    xfer(1'b1, 8'h08, 32'h06);
    xfer(1'b1, 8'h00, 32'h01);
    repeat (4) @(posedge hclk);
    rc(8'h10, 32'hff, 32'h5a);
    xfer(1'b1, 8'h08, 32'h05);
    xfer(1'b1, 8'h00, 32'h01);
    repeat (4) @(posedge hclk);
    rc(8'h10, 32'hff, 32'h3c);
    // a warm reset in mid-write must leave the error flag for firmware
    unl;
    xfer(1'b1, 8'h00, 32'h06);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rc(8'h00, 32'h0f, 32'h08);
    close_out;
  end
endmodule // eeprom_write_guard_bench

// ### ewg_defines.vh
// register map, field positions, reset values and timing counts of the eeprom write guard
`ifndef EWG_DEFINES_VH
`define EWG_DEFINES_VH
`define EWG_OFF_CTRL 8'h00
`define EWG_OFF_UNLOCK 8'h04
`define EWG_OFF_ADDR_LO 8'h08
`define EWG_OFF_ADDR_HI 8'h0c
`define EWG_OFF_DATA_LO 8'h10
`define EWG_OFF_DATA_HI 8'h14
`define EWG_OFF_INTCTL 8'h18
`define EWG_OFF_IRQ_EN 8'h1c
`define EWG_OFF_IRQ_FLAG 8'h20
`define EWG_OFF_IRQ_CLR 8'h24
`define EWG_OFF_FUSE 8'h28
`define EWG_BIT_RD 0
`define EWG_BIT_WR 1
`define EWG_BIT_WRITE_ENABLE_LATCH 2
`define EWG_BIT_WRITE_ERROR_FLAG 3
`define EWG_BIT_PGD 7
`define EWG_BIT_DONE 4
`define EWG_BIT_DENY 0
`define EWG_CTRL_MASK 8'h8f
`define EWG_ADDR_HI_MASK 8'h0f
`define EWG_DATA_HI_MASK 8'h3f
`define EWG_IRQ_MASK 8'hf0
`define EWG_IRQ_STAT_MASK 8'h11
`define EWG_UNLOCK_B1 8'h55
`define EWG_UNLOCK_B2 8'haa
`define EWG_RST_BYTE 8'h00
`define EWG_PWRT_MS 64
`define EWG_CLK_MHZ 200
`define EWG_PWRT_CYCLES (`EWG_PWRT_MS * 1000 * `EWG_CLK_MHZ)
`define EWG_WRITE_CYCLES 16
`define EWG_MEM_DEPTH 256
`endif

// ### ewg_guard.v
// eeprom write guard: ahb-lite register file, unlock, power-up timer and write sequencer
//
// Behaviour
// - a power-on reset clears the write-enable latch so no write starts until firmware sets it again.
// - while the 64 ms power-up timer runs no eeprom write may start.
// - a write starts only with the enable latch set and the unlock sequence just completed.
// - with the data protect fuse at 0 only the cpu may read or write the eeprom; the external path is denied.
// - other resets clear write, read and enable bits, keep the error flag by condition; unused bits read 0.
// - setting write-start with program space selected clears it at once and does nothing.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ewg_defines.vh"
module ewg_guard #(
  parameter PWRT_CYCLES = `EWG_PWRT_CYCLES
) (
  input wire hclk,
  input wire hresetn,
  input wire por_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire data_protect_fuse,
  input wire ext_req,
  input wire ext_wr,
  input wire [7:0] ext_addr,
  input wire [7:0] ext_wdata,
  output reg [7:0] ext_rdata_ff,
  output reg ext_deny_ff,
  output wire irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WRITE = 2'd1;
  localparam UL_NONE = 2'd0;
  localparam UL_ONE = 2'd1;
  localparam UL_DONE = 2'd2;

  function sel_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      sel_hit = (a == off);
    end
  endfunction

  reg [7:0] ctrl_ff;
  reg [7:0] addr_lo_ff;
  reg [7:0] addr_hi_ff;
  reg [7:0] data_lo_ff;
  reg [7:0] data_hi_ff;
  reg [7:0] intctl_ff;
  reg [7:0] irq_en_ff;
  reg [7:0] irq_flag_ff;
  reg [1:0] unlock_ff;
  reg [1:0] state_ff;
  reg [4:0] wcnt_ff;
  reg [31:0] pwrt_ff;
  reg was_writing_ff;
  reg err_pending_ff;
  reg dph_ff;
  reg dph_wr_ff;
  reg [7:0] dph_addr_ff;
  reg [31:0] hrdata_ff;
  reg rd_pend_ff;
  reg ext_pend_ff;

  wire pwrt_busy = (pwrt_ff != 32'h0);
  wire addr_phase = hsel && hready && htrans[1];
  wire bus_wr = dph_ff && dph_wr_ff;
  wire [7:0] wb = hwdata[7:0];
  wire wr_ctrl = bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_CTRL);
  wire wr_unlock = bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_UNLOCK);
  wire wr_start = wr_ctrl && wb[`EWG_BIT_WR] && !ctrl_ff[`EWG_BIT_WR];
  wire rd_start = wr_ctrl && wb[`EWG_BIT_RD];
  wire write_enable_latch_next = wr_ctrl ? wb[`EWG_BIT_WRITE_ENABLE_LATCH] : ctrl_ff[`EWG_BIT_WRITE_ENABLE_LATCH];
  // the start bit itself must be written after the unlock, never alongside it
  wire start_ok = wr_start && !wb[`EWG_BIT_PGD] && write_enable_latch_next && (unlock_ff == UL_DONE) && !pwrt_busy;
  wire write_done = (state_ff == ST_WRITE) && (wcnt_ff == 5'd0);
  wire [31:0] wcnt_load = `EWG_WRITE_CYCLES - 1;
  // external path shares the array; the cpu wins only while its write runs, an idle external request takes the array address
  wire ext_ok = ext_req && data_protect_fuse && (state_ff == ST_IDLE) && !pwrt_busy;
  wire mem_we = write_done || (ext_ok && ext_wr && !write_done);
  wire [7:0] mem_addr = (ext_ok && !(state_ff == ST_WRITE)) ? ext_addr : addr_lo_ff;
  wire [7:0] mem_wdata = write_done ? data_lo_ff : ext_wdata;
  wire [7:0] mem_rdata;

  ewg_mem u_mem (
    .hclk(hclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_ff(mem_rdata)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign irq = |(irq_flag_ff & irq_en_ff & `EWG_IRQ_STAT_MASK);

  // bus data phase tracking and read mux
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      dph_wr_ff <= 1'b0;
      dph_addr_ff <= `EWG_RST_BYTE;
      hrdata_ff <= 32'h0;
    end else begin
      dph_ff <= addr_phase;
      dph_wr_ff <= addr_phase && hwrite;
      dph_addr_ff <= haddr[7:0];
      hrdata_ff <= 32'h0;
      // read data registered in the address phase so it stands in the data phase
      if (addr_phase && !hwrite) begin
        case (haddr[7:0])
          `EWG_OFF_CTRL: hrdata_ff <= {24'h0, ctrl_ff & `EWG_CTRL_MASK};
          `EWG_OFF_ADDR_LO: hrdata_ff <= {24'h0, addr_lo_ff};
          `EWG_OFF_ADDR_HI: hrdata_ff <= {24'h0, addr_hi_ff};
          `EWG_OFF_DATA_LO: hrdata_ff <= {24'h0, data_lo_ff};
          `EWG_OFF_DATA_HI: hrdata_ff <= {24'h0, data_hi_ff};
          `EWG_OFF_INTCTL: hrdata_ff <= {24'h0, intctl_ff};
          `EWG_OFF_IRQ_EN: hrdata_ff <= {24'h0, irq_en_ff};
          `EWG_OFF_IRQ_FLAG: hrdata_ff <= {24'h0, irq_flag_ff};
          `EWG_OFF_FUSE: hrdata_ff <= {31'h0, data_protect_fuse};
          default: hrdata_ff <= 32'h0;
        endcase
      end
    end
  end

  // power-up timer runs only after a power-on reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwrt_ff <= 32'h0;
    end else begin
      if (!por_n) begin
        pwrt_ff <= PWRT_CYCLES;
      end else if (pwrt_busy) begin
        pwrt_ff <= pwrt_ff - 32'h1;
      end
    end
  end

  // remembers an interrupted write across a non-power reset
  // no reset here: the write-in-progress mark must outlive the reset that it reports
  always @(posedge hclk) begin
    if (hresetn) begin
      was_writing_ff <= (state_ff == ST_WRITE);
    end
    err_pending_ff <= !hresetn && was_writing_ff && por_n;
  end

  // control, unlock and write sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `EWG_RST_BYTE;
      unlock_ff <= UL_NONE;
      state_ff <= ST_IDLE;
      wcnt_ff <= 5'd0;
      rd_pend_ff <= 1'b0;
    end else begin
      rd_pend_ff <= 1'b0;
      if (!por_n) begin
        ctrl_ff <= `EWG_RST_BYTE;
        unlock_ff <= UL_NONE;
        state_ff <= ST_IDLE;
      end else begin
        if (err_pending_ff) begin
          ctrl_ff[`EWG_BIT_WRITE_ERROR_FLAG] <= 1'b1;
        end
        if (wr_unlock) begin
          if (wb == `EWG_UNLOCK_B1) begin
            unlock_ff <= UL_ONE;
          end else if (wb == `EWG_UNLOCK_B2 && unlock_ff == UL_ONE) begin
            unlock_ff <= UL_DONE;
          end else begin
            unlock_ff <= UL_NONE;
          end
        end else if (bus_wr) begin
          unlock_ff <= UL_NONE;
        end
        if (wr_ctrl) begin
          ctrl_ff[`EWG_BIT_PGD] <= wb[`EWG_BIT_PGD];
          ctrl_ff[`EWG_BIT_WRITE_ENABLE_LATCH] <= wb[`EWG_BIT_WRITE_ENABLE_LATCH];
          if (!wb[`EWG_BIT_WRITE_ERROR_FLAG] && !err_pending_ff) begin
            ctrl_ff[`EWG_BIT_WRITE_ERROR_FLAG] <= 1'b0;
          end
          if (rd_start && !wb[`EWG_BIT_PGD] && state_ff == ST_IDLE) begin
            rd_pend_ff <= 1'b1;
          end
        end
        case (state_ff)
          ST_IDLE: begin
            // program-space start, locked start and timer-blocked start all drop the bit
            if (start_ok) begin
              ctrl_ff[`EWG_BIT_WR] <= 1'b1;
              state_ff <= ST_WRITE;
              wcnt_ff <= wcnt_load[4:0];
              unlock_ff <= UL_NONE;
            end else begin
              ctrl_ff[`EWG_BIT_WR] <= 1'b0;
            end
          end
          ST_WRITE: begin
            if (write_done) begin
              ctrl_ff[`EWG_BIT_WR] <= 1'b0;
              state_ff <= ST_IDLE;
            end else begin
              wcnt_ff <= wcnt_ff - 5'd1;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
        ctrl_ff[`EWG_BIT_RD] <= 1'b0;
      end
    end
  end

  // data, address and interrupt registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_lo_ff <= `EWG_RST_BYTE;
      addr_hi_ff <= `EWG_RST_BYTE;
      data_lo_ff <= `EWG_RST_BYTE;
      data_hi_ff <= `EWG_RST_BYTE;
      intctl_ff <= `EWG_RST_BYTE;
      irq_en_ff <= `EWG_RST_BYTE;
      irq_flag_ff <= `EWG_RST_BYTE;
      ext_rdata_ff <= `EWG_RST_BYTE;
      ext_deny_ff <= 1'b0;
      ext_pend_ff <= 1'b0;
    end else begin
      ext_pend_ff <= ext_ok && !ext_wr;
      ext_deny_ff <= ext_req && !data_protect_fuse;
      if (ext_pend_ff) begin
        ext_rdata_ff <= mem_rdata;
      end
      if (bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_ADDR_LO)) addr_lo_ff <= wb;
      if (bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_ADDR_HI)) addr_hi_ff <= wb & `EWG_ADDR_HI_MASK;
      if (bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_DATA_HI)) data_hi_ff <= wb & `EWG_DATA_HI_MASK;
      if (bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_INTCTL)) intctl_ff <= wb;
      if (bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_IRQ_EN)) irq_en_ff <= wb & `EWG_IRQ_MASK;
      if (rd_pend_ff) begin
        data_lo_ff <= mem_rdata;
      end else if (bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_DATA_LO)) begin
        data_lo_ff <= wb;
      end
      // set wins over clear: clear first, then events
      if (bus_wr && sel_hit(dph_addr_ff, `EWG_OFF_IRQ_CLR)) begin
        irq_flag_ff <= (irq_flag_ff & ~wb) | {3'b000, write_done, 3'b000, ext_deny_ff};
      end else begin
        irq_flag_ff <= irq_flag_ff | {3'b000, write_done, 3'b000, ext_deny_ff};
      end
    end
  end
endmodule // ewg_guard

// ### ewg_guard_props.sv
// checker: bus, protection and interrupt relations at the eeprom write guard ports
`timescale 1ns/1ps
module ewg_guard_props #(
  parameter PWRT_CYCLES = 20
) (
  input wire hclk,
  input wire hresetn,
  input wire por_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire data_protect_fuse,
  input wire ext_req,
  input wire ext_deny_ff,
  input wire irq
);
  reg rd_ff;
  reg ctl_ff;
  reg [31:0] pcnt_ff;
  wire take = hsel & hready & htrans[1] & ~hwrite;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff <= 1'b0;
      ctl_ff <= 1'b0;
    end else begin
      rd_ff <= take;
      ctl_ff <= take & (haddr[7:0] == 8'h00);
    end
  end
  // counts from por_n only, a warm reset must not restart it
  always @(posedge hclk) begin
    if (!por_n) pcnt_ff <= 32'h0;
    else if (pcnt_ff < PWRT_CYCLES) pcnt_ff <= pcnt_ff + 32'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bus answer not okay");
  AST_DENY: assert property (ext_req && !data_protect_fuse |=> ext_deny_ff) else $error("external access not denied");
  AST_NO_DENY: assert property (!ext_req || data_protect_fuse |=> !ext_deny_ff) else $error("spurious deny");
  AST_UPPER: assert property (rd_ff |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_IDLE: assert property (!rd_ff |-> hrdata == 32'h0) else $error("read data outside data phase");
  AST_CTRL_GAP: assert property (ctl_ff |-> hrdata[6:4] == 3'b000) else $error("unused control bits set");
  // half the interval keeps clear of the exact end edge of the timer
  AST_PWRT: assert property (ctl_ff && pcnt_ff < PWRT_CYCLES / 2 |-> !hrdata[1]) else $error("write during timer");
  AST_IRQ_RST: assert property ($rose(hresetn) |-> !irq && !ext_deny_ff) else $error("outputs set after reset");
endmodule // ewg_guard_props
bind ewg_guard ewg_guard_props #(.PWRT_CYCLES(PWRT_CYCLES)) i_props (.hclk, .hresetn, .por_n, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .data_protect_fuse, .ext_req, .ext_deny_ff, .irq);

// ### ewg_mem.v
// data eeprom array model: 256 bytes with registered read data
`timescale 1ns/1ps
`include "ewg_defines.vh"
module ewg_mem (
  input wire hclk,
  input wire we,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_ff
);
  reg [7:0] mem [0:`EWG_MEM_DEPTH-1];
  // no reset on the array: content is meant to survive resets
  always @(posedge hclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end
endmodule // ewg_mem
